// ==== design/vfu_defs.svh ====
// Constants of the vector and floating-point functional units.
// Assumes inclusion by the package and the design modules only.
`ifndef VFU_DEFS_SVH
`define VFU_DEFS_SVH
// ----------------------------------------------------------------
// Floating-point format
// ----------------------------------------------------------------
`define FP_BIAS 18'h04000
`define FP_OVF_EXP 15'h6000
`define FP_OVF_MIN 18'h06000
`define FP_UNF_MAX 18'h01FFF
`define HALF_RND 48'h0000_0004_0000
`define HALF_MSK 48'hFFFF_FFF8_0000
`define RCP_NUM 96'h8000_0000_0000_0000_0000_0000
`define RCP_EXP 18'h08001
// ----------------------------------------------------------------
// Bit matrix multiplier
// ----------------------------------------------------------------
`define MAT_N 64
`endif

// ==== design/vfu_pkg.sv ====
// Types shared by the functional units.
// Assumes the constants header is on the include path.
package vfu_pkg;
  `include "vfu_defs.svh"

  typedef enum logic [4:0] {
    OP_NOP, OP_VADD, OP_VSUB, OP_SHL, OP_SHR, OP_DSHL, OP_DSHR,
    OP_AND, OP_OR, OP_XOR, OP_EQV, OP_MERGE, OP_CIDX, OP_VMTEST,
    OP_POP, OP_PAR, OP_LZC, OP_BMLD, OP_BMM, OP_BMMS,
    OP_FADD, OP_FSUB, OP_FMUL, OP_FMULR, OP_FMULH, OP_FMULI32, OP_FRCP
  } op_t;

  typedef enum logic [3:0] {
    U_NONE, U_ADD, U_SHIFT, U_LOG1, U_LOG2, U_CNT1, U_CNT2, U_BMM,
    U_FADD, U_FMUL, U_FRCP
  } unit_t;

  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic inst;
    logic scal;
    logic [6:0] idx;
    op_t op;
    logic [63:0] a;
    logic [63:0] b;
    logic [63:0] c;
    logic [6:0] cnt;
    logic [7:0] vl;
    logic sec_en;
  } iss_t;

  typedef struct packed {
    logic valid;
    logic scal;
    logic pipe;
    unit_t unit;
    logic [63:0] data;
    logic ovf;
    logic unf;
  } res_t;

  typedef struct packed {
    iss_t s1;
    logic c2;
    logic l2;
    logic [1:0] busy_c;
    logic [1:0] busy_l;
    logic [1:0] rt_c;
    logic [1:0] rt_l;
    logic [`MAT_N-1:0][63:0] mat;
    res_t res;
  } st_t;
endpackage

// ==== design/count_unit.sv ====
// Population, parity and leading-zero counting of one 64-bit word.
// Assumes a registered operand; the result is combinational.
`timescale 1ns/1ps
module count_unit import vfu_pkg::*; (
  input wire op_t op,
  input wire logic [63:0] d,
  output logic [63:0] r
);
  logic [6:0] pc;
  logic [6:0] lz;

  always_comb begin
    pc = 7'h00;
    lz = 7'h40;
    for (int i = 0; i < 64; i++) begin
      pc = pc + 7'(d[i]);
      if (d[i]) begin
        lz = 7'(63 - i);
      end
    end
    case (op)
      OP_POP: r = {57'h0, pc};
      OP_PAR: r = {63'h0, pc[0]};
      OP_LZC: r = {57'h0, lz};
      default: r = 64'h0;
    endcase
  end
endmodule

// ==== design/fp_set.sv ====
// One set of floating-point add, multiply and reciprocal units.
// Assumes registered operands; the result is combinational.
`timescale 1ns/1ps
module fp_set import vfu_pkg::*; (
  input wire op_t op,
  input wire logic [63:0] a,
  input wire logic [63:0] b,
  output logic [63:0] r,
  output logic ovf,
  output logic unf
);
  logic [14:0] ea, eb;
  logic [47:0] ma, mb, c;
  logic [95:0] p, q;
  logic [31:0] pi;
  logic [48:0] mx, my, s;
  logic [17:0] er;
  logic sx, sy, iovf, fl, ov, uf, rb;
  logic [6:0] lz;

  always_comb begin
    ea = a[62:48];
    eb = b[62:48];
    ma = a[47:0];
    mb = b[47:0];
    p = {48'h0, ma} * {48'h0, mb};
    pi = a[62:31] * b[47:16];
    iovf = (ea[14:13] == 2'b11) || (eb[14:13] == 2'b11);
    r = 64'h0;
    c = 48'h0;
    er = 18'h0;
    sx = 1'b0;
    sy = 1'b0;
    mx = 49'h0;
    my = 49'h0;
    s = 49'h0;
    q = 96'h0;
    lz = 7'h0;
    fl = 1'b0;
    rb = 1'b0;
    case (op)
      OP_FADD, OP_FSUB: begin
        sy = b[63] ^ (op == OP_FSUB);
        if (ea >= eb) begin
          sx = a[63];
          er = 18'(ea);
          mx = {1'b0, ma};
          my = {1'b0, mb} >> (ea - eb);
        end else begin
          sx = sy;
          sy = a[63];
          er = 18'(eb);
          mx = {1'b0, mb};
          my = {1'b0, ma} >> (eb - ea);
        end
        if (sx == sy) begin
          s = mx + my;
        end else if (mx >= my) begin
          s = mx - my;
        end else begin
          s = my - mx;
          sx = sy;
        end
        // Normalized whatever the operands were, except when the sum is zero.
        if (s[48]) begin
          c = s[48:1];
          er = er + 18'h1;
        end else begin
          lz = 7'd48;
          for (int i = 0; i < 48; i++) begin
            if (s[i]) begin
              lz = 7'(47 - i);
            end
          end
          c = s[47:0] << lz;
          er = er - 18'(lz);
        end
        fl = 1'b1;
      end
      OP_FMUL, OP_FMULR, OP_FMULH: begin
        sx = a[63] ^ b[63];
        if (ea == 15'h0 && eb == 15'h0) begin
          r = {sx, 15'h0, p[95:48]};
        end else begin
          er = 18'(ea) + 18'(eb) - `FP_BIAS;
          if (ma[47] && mb[47] && !p[95]) begin
            c = p[94:47];
            rb = p[46];
            er = er - 18'h1;
          end else begin
            c = p[95:48];
            rb = p[47];
          end
          if (op != OP_FMUL) begin
            c = c + 48'(rb);
          end
          if (op == OP_FMULH) begin
            c = (c + `HALF_RND) & `HALF_MSK;
          end
          fl = 1'b1;
        end
      end
      OP_FMULI32: begin
        r = {32'h0, pi};
      end
      OP_FRCP: begin
        iovf = (ea[14:13] == 2'b11);
        sx = a[63];
        q = `RCP_NUM / {48'h0, 1'b1, ma[46:0]};
        c = q[48] ? 48'hFFFF_FFFF_FFFF : q[47:0];
        er = `RCP_EXP - 18'(ea);
        fl = 1'b1;
      end
      default: begin
        r = 64'h0;
      end
    endcase
    ov = fl && c != 48'h0 && (iovf || (!er[17] && er >= `FP_OVF_MIN));
    uf = fl && c != 48'h0 && !ov && (er[17] || er <= `FP_UNF_MAX);
    if (fl) begin
      if (c == 48'h0 || uf) begin
        r = 64'h0;
      end else if (ov) begin
        r = {sx, `FP_OVF_EXP, (op == OP_FRCP) ? 1'b0 : c[47], c[46:0]};
      end else begin
        r = {sx, er[14:0], c};
      end
    end
    ovf = ov;
    unf = uf && op == OP_FRCP;
  end
endmodule

// ==== design/vector_fp_units.sv ====
// Vector integer, logical, counting, bit matrix and floating-point units.
// Assumes one issue per cycle from the issue logic on the same clock.
`timescale 1ns/1ps

module vector_fp_units import vfu_pkg::*; (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic cnt2_fitted,
  input wire iss_t iss,
  output res_t result
);
  st_t st_q, st_d;
  logic is_cnt, is_log, full_only, c2, l2;
  logic [63:0] cnt_r [2];
  logic [63:0] fp_r [2];
  logic fp_o [2];
  logic fp_u [2];
  logic [63:0] bmm_v;
  logic [127:0] dsh;
  logic pipe;

  // ----------------------------------------------------------------
  // Counting units and floating-point sets
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_dup
    count_unit u_cnt (
      .op(st_q.s1.op),
      .d(st_q.s1.a),
      .r(cnt_r[g])
    );
    fp_set u_fp (
      .op(st_q.s1.op),
      .a(st_q.s1.a),
      .b(st_q.s1.b),
      .r(fp_r[g]),
      .ovf(fp_o[g]),
      .unf(fp_u[g])
    );
  end

  // ----------------------------------------------------------------
  // Bit matrix multiplier, one parity term per matrix row
  // ----------------------------------------------------------------
  for (genvar j = 0; j < `MAT_N; j++) begin : g_bmm
    assign bmm_v[`MAT_N-1-j] = (8'(j) < st_q.s1.vl) &&
                               (^(st_q.s1.a & st_q.mat[j]));
  end

  // ----------------------------------------------------------------
  // Issue routing and result stage
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    is_cnt = iss.op inside {OP_POP, OP_PAR, OP_LZC};
    full_only = iss.op inside {OP_MERGE, OP_CIDX, OP_VMTEST};
    is_log = iss.op inside {OP_AND, OP_OR, OP_XOR, OP_EQV};
    c2 = iss.first ? (st_q.busy_c[0] && cnt2_fitted) : st_q.rt_c[iss.inst];
    l2 = iss.first ? (iss.sec_en && st_q.busy_l[0]) : st_q.rt_l[iss.inst];
    if (!is_log) begin
      l2 = 1'b0;
    end
    // A one-element instruction neither takes nor frees a reservation.
    if (iss.valid && is_cnt) begin
      if (iss.first) begin
        st_d.rt_c[iss.inst] = c2;
      end
      if (iss.first && !iss.last) begin
        st_d.busy_c[c2] = 1'b1;
      end
      if (iss.last && !iss.first) begin
        st_d.busy_c[c2] = 1'b0;
      end
    end
    if (iss.valid && (is_log || full_only)) begin
      if (iss.first) begin
        st_d.rt_l[iss.inst] = l2;
      end
      if (iss.first && !iss.last) begin
        st_d.busy_l[l2] = 1'b1;
      end
      if (iss.last && !iss.first) begin
        st_d.busy_l[l2] = 1'b0;
      end
    end
    st_d.s1 = iss;
    st_d.c2 = c2;
    st_d.l2 = l2;

    dsh = 128'h0;
    pipe = st_q.s1.scal ? 1'b0 : st_q.s1.idx[0];
    st_d.res = '0;
    st_d.res.valid = st_q.s1.valid;
    st_d.res.scal = st_q.s1.scal;
    st_d.res.pipe = st_q.s1.idx[0];
    if (st_q.s1.valid) begin
      case (st_q.s1.op)
        OP_VADD: begin
          st_d.res.unit = U_ADD;
          st_d.res.data = st_q.s1.a + st_q.s1.b;
        end
        OP_VSUB: begin
          st_d.res.unit = U_ADD;
          st_d.res.data = st_q.s1.a + ~st_q.s1.b + 64'h1;
        end
        OP_SHL: begin
          st_d.res.unit = U_SHIFT;
          st_d.res.data = st_q.s1.a << st_q.s1.cnt;
        end
        OP_SHR: begin
          st_d.res.unit = U_SHIFT;
          st_d.res.data = st_q.s1.a >> st_q.s1.cnt;
        end
        OP_DSHL: begin
          st_d.res.unit = U_SHIFT;
          dsh = {st_q.s1.a, st_q.s1.c} << st_q.s1.cnt;
          st_d.res.data = dsh[127:64];
        end
        OP_DSHR: begin
          st_d.res.unit = U_SHIFT;
          dsh = {st_q.s1.c, st_q.s1.a} >> st_q.s1.cnt;
          st_d.res.data = dsh[63:0];
        end
        OP_AND, OP_OR, OP_XOR, OP_EQV: begin
          st_d.res.unit = st_q.l2 ? U_LOG2 : U_LOG1;
          case (st_q.s1.op)
            OP_AND: st_d.res.data = st_q.s1.a & st_q.s1.b;
            OP_OR: st_d.res.data = st_q.s1.a | st_q.s1.b;
            OP_XOR: st_d.res.data = st_q.s1.a ^ st_q.s1.b;
            default: st_d.res.data = ~(st_q.s1.a ^ st_q.s1.b);
          endcase
        end
        OP_MERGE: begin
          st_d.res.unit = U_LOG1;
          st_d.res.data = (st_q.s1.a & st_q.s1.c) |
                          (st_q.s1.b & ~st_q.s1.c);
        end
        OP_CIDX: begin
          st_d.res.unit = U_LOG1;
          st_d.res.valid = st_q.s1.c[0];
          st_d.res.data = {57'h0, st_q.s1.idx};
        end
        OP_VMTEST: begin
          st_d.res.unit = U_LOG1;
          st_d.res.data = {63'h0, st_q.s1.a == 64'h0};
        end
        OP_POP, OP_PAR, OP_LZC: begin
          st_d.res.unit = st_q.c2 ? U_CNT2 : U_CNT1;
          st_d.res.data = cnt_r[st_q.c2];
        end
        OP_BMLD: begin
          st_d.res.valid = 1'b0;
          st_d.mat[st_q.s1.idx[5:0]] = st_q.s1.a;
        end
        OP_BMM, OP_BMMS: begin
          st_d.res.unit = U_BMM;
          st_d.res.scal = (st_q.s1.op == OP_BMMS);
          st_d.res.data = bmm_v;
        end
        OP_FADD, OP_FSUB, OP_FMUL, OP_FMULR, OP_FMULH, OP_FMULI32, OP_FRCP: begin
          st_d.res.pipe = pipe;
          st_d.res.unit = (st_q.s1.op == OP_FRCP) ? U_FRCP :
                          (st_q.s1.op inside {OP_FADD, OP_FSUB}) ? U_FADD : U_FMUL;
          st_d.res.data = fp_r[pipe];
          st_d.res.ovf = fp_o[pipe];
          st_d.res.unf = fp_u[pipe];
        end
        default: begin
          st_d.res.valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign result = st_q.res;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_add_latency: assert property (
    (ce && iss.valid && iss.op == OP_VADD) ##1 ce |=>
      result.valid && result.unit == U_ADD &&
      result.data == $past(iss.a, 2) + $past(iss.b, 2))
    else $error("vector add result wrong or late");

  a_sub_twos: assert property (
    (ce && iss.valid && iss.op == OP_VSUB) ##1 ce |=>
      result.data == $past(iss.a, 2) - $past(iss.b, 2))
    else $error("vector subtract result wrong");

  a_shift_fill: assert property (
    (ce && iss.valid && iss.op == OP_SHR) ##1 ce |=>
      result.data == ($past(iss.a, 2) >> $past(iss.cnt, 2)))
    else $error("single right shift result wrong");

  a_merge_mask: assert property (
    (ce && iss.valid && iss.op == OP_MERGE) ##1 ce |=>
      result.unit == U_LOG1 &&
      result.data == (($past(iss.a, 2) & $past(iss.c, 2)) |
                      ($past(iss.b, 2) & ~$past(iss.c, 2))))
    else $error("merge result wrong");

  a_eqv_result: assert property (
    (ce && iss.valid && iss.op == OP_EQV) ##1 ce |=>
      result.data == ~($past(iss.a, 2) ^ $past(iss.b, 2)))
    else $error("equivalence result wrong");

  a_sec_logic_off: assert property (
    (ce && iss.valid && iss.first && !iss.sec_en && iss.op == OP_AND) ##1 ce |=>
      result.unit == U_LOG1)
    else $error("second logical unit used while disabled");

  a_cnt2_dispatch: assert property (
    (ce && iss.valid && iss.first && iss.op == OP_POP && cnt2_fitted &&
     st_q.busy_c[0]) ##1 ce |=> result.unit == U_CNT2)
    else $error("busy counter not bypassed to second unit");

  a_lzc_zero: assert property (
    (ce && iss.valid && iss.op == OP_LZC && iss.a == 64'h0) ##1 ce |=>
      result.data == 64'h40)
    else $error("leading zero count of zero wrong");

  a_int_mul_sign: assert property (
    (ce && iss.valid && iss.op == OP_FMUL && iss.a[62:48] == 15'h0 &&
     iss.b[62:48] == 15'h0) ##1 ce |=>
      result.data[62:48] == 15'h0 && !result.ovf &&
      result.data[63] == ($past(iss.a[63], 2) ^ $past(iss.b[63], 2)))
    else $error("integer multiply sign or exponent wrong");

  a_add_no_unf: assert property (
    result.valid && result.unit inside {U_FADD, U_FMUL} |-> !result.unf)
    else $error("add or multiply flagged underflow");

  a_rcp_ovf_flag: assert property (
    (ce && iss.valid && iss.op == OP_FRCP && iss.a[62:61] == 2'b11 &&
     iss.a[46:0] != 47'h0) ##1 ce |=> result.ovf && !result.data[47])
    else $error("reciprocal overflow not flagged");

  a_scalar_set0: assert property (
    (ce && iss.valid && iss.scal && iss.op == OP_FADD) ##1 ce |=>
      result.pipe == 1'b0)
    else $error("scalar float op not on set zero");

  c_vadd: cover property (ce && iss.valid && iss.op == OP_VADD ##2 result.valid);
  c_cnt2: cover property (result.valid && result.unit == U_CNT2);
  c_bmm_scalar: cover property (result.valid && result.unit == U_BMM && result.scal);
  c_fp_odd: cover property (result.valid && result.unit == U_FMUL && result.pipe);
endmodule

// ==== test/issue_model.sv ====
// Issue-side model that presents one element per cycle to the units.
// Assumes the bench calls its tasks from one process on the shared clock.
`timescale 1ns/1ps
module issue_model import vfu_pkg::*; (
  input wire logic clock,
  output iss_t iss
);
  initial iss = '0;

  // Presents one element, changed just after the rising edge.
  task automatic send(input iss_t x);
    @(posedge clock);
    iss <= x;
  endtask

  // Drops valid; operands keep toggling so stale values are never relied on.
  task automatic idle();
    @(posedge clock);
    iss.valid <= 1'b0;
    iss.a <= ~iss.a;
    iss.b <= ~iss.b;
    iss.c <= ~iss.c;
  endtask
endmodule

// ==== test/vector_fp_units_bench.sv ====
// Self-checking bench for the vector and floating-point functional units.
// Assumes the package, the design modules and the issue model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module vector_fp_units_bench;
  import vfu_pkg::*;
  typedef struct packed {
    unit_t unit;
    logic [63:0] data;
    logic pipe;
    logic scal;
    logic ovf;
  } exp_t;
  logic want_ovf = 1'b0;
  logic clock;
  logic rstn;
  logic ce;
  logic cnt2_fitted;
  iss_t iss;
  res_t result;
  iss_t x;
  exp_t eq[$];
  exp_t e;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [63:0] seed = 64'd88362;
  logic [127:0] w;
  logic [23:0] m1;
  logic [23:0] m2;
  logic [31:0] n1;
  logic [31:0] n2;
  op_t ops[16] = '{OP_VADD, OP_VSUB, OP_SHL, OP_SHR, OP_DSHL, OP_DSHR, OP_AND, OP_OR,
    OP_XOR, OP_EQV, OP_MERGE, OP_CIDX, OP_VMTEST, OP_POP, OP_PAR, OP_LZC};

  issue_model pm (.clock(clock), .iss(iss));
  vector_fp_units uut (.clock(clock), .rstn(rstn), .ce(ce), .cnt2_fitted(cnt2_fitted),
    .iss(iss), .result(result));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  function automatic logic [63:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 7);
    seed = seed ^ (seed << 17);
    return seed;
  endfunction

  // Expected data of the integer, logical and counting operations.
  function automatic logic [63:0] model(iss_t v);
    logic [63:0] n;
    n = '0;
    case (v.op)
      OP_VADD: n = v.a + v.b;
      OP_VSUB: n = v.a + ~v.b + 64'h1;
      OP_SHL: n = v.a << v.cnt;
      OP_SHR: n = v.a >> v.cnt;
      OP_DSHL: n = 64'(({v.a, v.c} << v.cnt) >> 64);
      OP_DSHR: n = 64'({v.c, v.a} >> v.cnt);
      OP_AND: n = v.a & v.b;
      OP_OR: n = v.a | v.b;
      OP_XOR: n = v.a ^ v.b;
      OP_EQV: n = ~(v.a ^ v.b);
      OP_MERGE: n = (v.a & v.c) | (v.b & ~v.c);
      OP_CIDX: n = {57'h0, v.idx};
      OP_VMTEST: n = {63'h0, v.a == 64'h0};
      OP_POP: for (int i = 0; i < 64; i++) n = n + 64'(v.a[i]);
      OP_PAR: n = {63'h0, ^v.a};
      OP_LZC: begin
        n = 64'h40;
        for (int i = 0; i < 64; i++) if (v.a[i]) n = 64'(63 - i);
      end
      default: n = '0;
    endcase
    return n;
  endfunction

  function automatic unit_t unit_of(op_t op);
    case (op)
      OP_VADD, OP_VSUB: return U_ADD;
      OP_SHL, OP_SHR, OP_DSHL, OP_DSHR: return U_SHIFT;
      OP_POP, OP_PAR, OP_LZC: return U_CNT1;
      default: return U_LOG1;
    endcase
  endfunction

  task automatic init(op_t op);
    x = '0;
    want_ovf = 1'b0;
    x.op = op;
    x.first = 1'b1;
    x.last = 1'b1;
    x.idx = 7'(rnd());
    x.a = rnd();
    x.b = rnd();
    x.c = rnd();
    x.cnt = 7'(rnd() & 64'h3F);
  endtask

  // Issues the working element and notes the result it should give.
  task automatic go(unit_t u, logic [63:0] d, logic want);
    x.valid = 1'b1;
    if (want) eq.push_back('{u, d, x.scal ? 1'b0 : x.idx[0], x.scal, want_ovf});
    pm.send(x);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Results are taken at edges that advance the pipeline.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      final_report();
    end
    if (rstn && ce && result.valid === 1'b1) begin
      if (eq.size() == 0) begin
        `CHK("unexpected result", 1'b0, 1'b1)
      end else begin
        e = eq.pop_front();
        `CHK("unit", e.unit, result.unit)
        `CHK("data", e.data, result.data)
        `CHK("pipe", e.pipe, result.pipe)
        `CHK("scal", e.scal, result.scal)
        `CHK("ovf", e.ovf, result.ovf)
        `CHK("unf", 1'b0, result.unf)
      end
    end
  end

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    cnt2_fitted = 1'b0;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    // Every integer, logical and counting op back to back with edge operands.
    for (int t = 0; t < 6; t++) begin
      foreach (ops[k]) begin
        init(ops[k]);
        if (t == 0) x.a = 64'h0;
        if (t == 1) x.a = 64'hFFFF_FFFF_FFFF_FFFF;
        if (t < 2) x.cnt = t ? 7'h3F : 7'h00;
        go(unit_of(x.op), model(x), x.op != OP_CIDX || x.c[0]);
      end
    end
    // Overlapping instructions: second units taken only when allowed.
    for (int t = 0; t < 4; t++) begin
      cnt2_fitted <= t[0];
      init(OP_POP);
      x.last = 1'b0;
      go(U_CNT1, model(x), 1'b1);
      init(OP_LZC);
      x.inst = 1'b1;
      go(t[0] ? U_CNT2 : U_CNT1, model(x), 1'b1);
      init(OP_PAR);
      x.first = 1'b0;
      go(U_CNT1, model(x), 1'b1);
      init(OP_AND);
      x.last = 1'b0;
      go(U_LOG1, model(x), 1'b1);
      init(OP_XOR);
      x.inst = 1'b1;
      x.sec_en = t[1];
      go(t[1] ? U_LOG2 : U_LOG1, model(x), 1'b1);
      init(OP_MERGE);
      x.inst = 1'b1;
      x.sec_en = 1'b1;
      go(U_LOG1, model(x), 1'b1);
      init(OP_EQV);
      x.first = 1'b0;
      go(U_LOG1, model(x), 1'b1);
    end
    // Integer products through the multiplier, vector and scalar.
    for (int t = 0; t < 8; t++) begin
      m1 = 24'(rnd());
      m2 = 24'(rnd());
      init(OP_FMUL);
      x.scal = (t == 7);
      x.a = {x.a[63], 15'h0, m1, 24'h0};
      x.b = {x.b[63], 15'h0, m2, 24'h0};
      go(U_FMUL, {x.a[63] ^ x.b[63], 15'h0, 48'(m1) * 48'(m2)}, 1'b1);
      n1 = 32'(rnd());
      n2 = 32'(rnd());
      init(OP_FMULI32);
      x.a = {1'b0, n1, 31'h0};
      x.b = {16'h0, n2, 16'h0};
      w = 128'(n1) * 128'(n2);
      go(U_FMUL, {32'h0, w[31:0]}, 1'b1);
    end
    // Float add and reciprocal on both sets, scalar on set zero.
    for (int t = 0; t < 4; t++) begin
      init(OP_FADD);
      x.scal = (t == 3);
      x.a = 64'h4001_8000_0000_0000;
      x.b = 64'h4001_8000_0000_0000;
      go(U_FADD, 64'h4002_8000_0000_0000, 1'b1);
      init(OP_FRCP);
      x.a = {t[0], 15'h4001, 48'hC000_0000_0000};
      go(U_FRCP, {t[0], 15'h4000, 48'hAAAA_AAAA_AAAA}, 1'b1);
      init(OP_FRCP);
      x.a = 64'h6001_C000_0000_0000;
      want_ovf = 1'b1;
      go(U_FRCP, 64'h6000_2AAA_AAAA_AAAA, 1'b1);
    end
    // Bit matrix rows loaded, then vector and scalar products.
    init(OP_BMLD);
    x.idx = 7'h00;
    x.a = 64'hFFFF_FFFF_FFFF_FFFF;
    go(U_NONE, 64'h0, 1'b0);
    init(OP_BMLD);
    x.idx = 7'h01;
    x.a = 64'h1;
    go(U_NONE, 64'h0, 1'b0);
    pm.idle();
    for (int t = 0; t < 2; t++) begin
      init(t ? OP_BMMS : OP_BMM);
      x.idx = 7'h00;
      x.scal = t[0];
      x.vl = t ? 8'h01 : 8'h02;
      x.a = 64'h3;
      go(U_BMM, t ? 64'h0 : 64'h4000_0000_0000_0000, 1'b1);
    end
    // A frozen clock enable holds the pipeline and its result.
    init(OP_VADD);
    go(U_ADD, model(x), 1'b1);
    pm.idle();
    ce <= 1'b0;
    repeat (4) @(posedge clock);
    ce <= 1'b1;
    repeat (6) pm.idle();
    `CHK("pending results", 0, eq.size())
    final_report();
  end
endmodule
